// File: bench/dtp_far_model.sv
// Far-side trigger receiver model that also drives the snapshot pin
`timescale 1ns/1ns
module dtp_far_model (
    input wire logic ref_clk,
    input wire logic primary_output,
    input wire logic secondary_output,
    input wire logic active_high,
    input wire logic snap_level,
    output logic snap_pin,
    output logic busy,
    output logic [31:0] p_cnt,
    output logic [31:0] s_cnt,
    output logic [31:0] p_width,
    output logic [31:0] s_width,
    output logic [31:0] p_rise,
    output logic [31:0] s_rise
);
    logic [31:0] cyc;
    logic [31:0] p_run;
    logic [31:0] s_run;
    logic p_on;
    logic s_on;

    // The source always drives the pin; the bench holds each level for several ticks
    assign snap_pin = snap_level;
    assign p_on = (primary_output === active_high);
    assign s_on = (secondary_output === active_high);
    assign busy = (p_run != 0) || (s_run != 0);

    initial begin
        {cyc, p_run, s_run, p_cnt, s_cnt, p_width, s_width, p_rise, s_rise} = '0;
    end

    // A pulse is counted only when it ends, so its width is known by then
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (p_on) begin
            if (p_run == 0) p_rise <= cyc;
            p_run <= p_run + 1;
        end else if (p_run != 0) begin
            p_width <= p_run;
            p_cnt <= p_cnt + 1;
            p_run <= '0;
        end
        if (s_on) begin
            if (s_run == 0) s_rise <= cyc;
            s_run <= s_run + 1;
        end else if (s_run != 0) begin
            s_width <= s_run;
            s_cnt <= s_cnt + 1;
            s_run <= '0;
        end
    end
endmodule : dtp_far_model

// File: bench/dual_trigger_pulse_output_bench.sv
// Self-checking bench for the dual trigger pulse output
`timescale 1ns/1ns
module dual_trigger_pulse_output_bench;
    import dtp_pkg::*;
    localparam int TICK = 50;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic [31:0] exp;
    } dtp_row_s;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic trig_req = 1'b0;
    logic snap_pin;
    logic primary_output;
    logic secondary_output;
    logic active_high = 1'b1;
    logic snap_level = 1'b0;
    logic busy;
    logic [31:0] p_cnt, s_cnt, p_width, s_width, p_rise, s_rise;
    logic [31:0] errors = 32'h0;
    logic [31:0] checks_done = 32'h0;
    logic [31:0] rd, p0, s0;
    dtp_row_s rows [11];
    logic [3:0] codes [10];

    dtp_trigger_out #(.TICK_CYC(TICK)) dtp_trigger_out_i (.ref_clk(ref_clk), .rst_b(rst_b),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .trig_req(trig_req), .snap_pin(snap_pin),
        .primary_output(primary_output), .secondary_output(secondary_output));

    dtp_far_model dtp_far_model_i (.ref_clk(ref_clk), .primary_output(primary_output),
        .secondary_output(secondary_output), .active_high(active_high),
        .snap_level(snap_level), .snap_pin(snap_pin), .busy(busy), .p_cnt(p_cnt),
        .s_cnt(s_cnt), .p_width(p_width), .s_width(s_width), .p_rise(p_rise),
        .s_rise(s_rise));

    initial begin
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run;
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done != 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    // Read data stand only in the cycle after the strobe
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : reg_read

    // Bounded wait: frequency mode with the secondary selected never goes quiet, so the limit ends it
    task automatic fire;
        int quiet;
        quiet = 0;
        @(posedge ref_clk);
        trig_req <= 1'b1;
        @(posedge ref_clk);
        trig_req <= 1'b0;
        for (int n = 0; n < 2000 && quiet < 400; n++) begin
            @(posedge ref_clk);
            quiet = busy ? 0 : quiet + 1;
        end
    endtask : fire

    task automatic wait_ticks(input int n);
        repeat (n * TICK) @(posedge ref_clk);
    endtask : wait_ticks

    initial begin
        rows = '{'{REG_WIDTH, 32'h13, 32'h0}, '{REG_WIDTH, 32'h14, 32'h28},
            '{REG_WIDTH, 32'h3B, 32'h28}, '{REG_WIDTH, 32'h3C, 32'h50},
            '{REG_SDELAY, 32'h64, 32'h78}, '{REG_WIDTH, 32'h27AC40, 32'h2625A0},
            '{REG_SWIDTH, 32'h3B, 32'h28}, '{REG_FDELAY, 32'h1E, 32'h1E},
            '{REG_CTRL, 32'h0F, 32'h0F}, '{REG_CTRL, 32'h04, 32'h04}, '{8'h20, 32'h55, 32'h0}};
        codes = '{4'h0, 4'h5, 4'h6, 4'h7, 4'h9, 4'hA, 4'hB, 4'hD, 4'hE, 4'hF};
        repeat (3) @(posedge ref_clk);
        check(reg_rdata, 32'h0);
        check({30'h0, primary_output, secondary_output}, 32'h0);
        rst_b <= 1'b1;
        reg_read(REG_CTRL, rd);
        check(rd, 32'h04);
        foreach (rows[i]) begin
            reg_write(rows[i].addr, rows[i].wdata);
            reg_read(rows[i].addr, rd);
            check(rd, rows[i].exp);
        end
        reg_write(REG_WIDTH, 32'h50);
        fire();
        check(p_width, 2 * TICK);
        check(s_width, p_width);
        check(s_rise, p_rise);
        reg_write(REG_WIDTH, 32'h0);
        fire();
        check(p_width, SPIKE_CYC);
        reg_write(REG_WIDTH, 32'hA0);
        reg_write(REG_FDELAY, 32'h1E);
        reg_write(REG_FWIDTH, 32'h12C);
        reg_write(REG_FHALF, 32'h7);
        foreach (codes[i]) begin
            reg_write(REG_CTRL, {24'h0, codes[i], 4'h4});
            p0 = p_cnt;
            s0 = s_cnt;
            fire();
            check({30'h0, s_cnt != s0, p_cnt != p0},
                {30'h0, codes[i][1:0] != 2'b01, codes[i][1:0] != 2'b10});
        end
        check(s_width, 32'h7);
        check(p_width, 4 * TICK);
        reg_write(REG_CTRL, 32'h74);
        fire();
        check(s_rise, p_rise);
        check(s_width, 32'h12C);
        reg_write(REG_CTRL, 32'hB4);
        fire();
        check(s_rise - p_rise, 32'h1E);
        check(s_width, 4 * TICK - 32'h1E);
        reg_write(REG_FDELAY, 32'h96);
        fire();
        check({31'h0, s_width > 0 && s_width <= TICK + 2}, 32'h1);
        reg_write(REG_FDELAY, 32'h15E);
        fire();
        check(s_rise - p_rise, 32'h15E);
        reg_write(REG_SDELAY, 32'h28);
        reg_write(REG_SWIDTH, 32'h28);
        reg_write(REG_CTRL, 32'h0C);
        fire();
        check(s_rise - p_rise, TICK);
        check(s_width, TICK);
        reg_write(REG_CTRL, 32'h00);
        active_high <= 1'b0;
        wait_ticks(1);
        check({30'h0, primary_output, secondary_output}, 32'h3);
        fire();
        check(p_width, 4 * TICK);
        active_high <= 1'b1;
        reg_write(REG_CTRL, 32'h07);
        wait_ticks(3);
        p0 = p_cnt;
        snap_level <= 1'b1;
        wait_ticks(8);
        check(p_cnt - p0, 32'h1);
        reg_read(REG_STATUS, rd);
        check(rd, 32'h4);
        snap_level <= 1'b0;
        wait_ticks(8);
        check(p_cnt - p0, 32'h1);
        reg_write(REG_CTRL, 32'h06);
        snap_level <= 1'b1;
        wait_ticks(8);
        check(p_cnt - p0, 32'h1);
        reg_write(REG_CTRL, 32'h04);
        wait_ticks(4);
        reg_write(REG_CTRL, 32'h75);
        wait_ticks(4);
        p0 = p_cnt;
        s0 = s_cnt;
        snap_level <= 1'b0;
        wait_ticks(10);
        check(p_cnt - p0, 32'h1);
        check(s_cnt - s0, 32'h1);
        check(s_width, 32'h12C);
        complete_run();
    end

    // The sequence takes about 17,000 cycles; this limit leaves ample margin
    initial begin
        #400000;
        errors = errors + 1;
        complete_run();
    end
endmodule : dual_trigger_pulse_output_bench

// File: shared/dtp_pkg.sv
// Constants, register map and state types of the dual trigger pulse output
package dtp_pkg;

    // Clock and timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int TICK_US = 40;
    localparam int TICK_CYC_DEF = (TICK_US * 1000) / CLK_PERIOD_NS;
    localparam int EARLY_NS = 1000;
    localparam int EARLY_CYC = (EARLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SPIKE_NS = 1000;
    localparam int SPIKE_CYC = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [22:0] ROUND_US = 23'h000014;
    localparam logic [22:0] MAX_US = 23'h2625A0;
    localparam logic [22:0] STEP_US = 23'h000028;

    // Register byte addresses
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_WIDTH = 8'h04;
    localparam logic [7:0] REG_SDELAY = 8'h08;
    localparam logic [7:0] REG_SWIDTH = 8'h0C;
    localparam logic [7:0] REG_FWIDTH = 8'h10;
    localparam logic [7:0] REG_FDELAY = 8'h14;
    localparam logic [7:0] REG_FHALF = 8'h18;
    localparam logic [7:0] REG_STATUS = 8'h1C;

    // Control register fields
    localparam int CTRL_SNAP_EN = 0;
    localparam int CTRL_SNAP_POL = 1;
    localparam int CTRL_OUT_POL = 2;
    localparam int CTRL_SEC_CUSTOM = 3;
    localparam int CTRL_SEL_LO = 4;

    // Status register fields
    localparam int STAT_PRIM = 0;
    localparam int STAT_SEC = 1;
    localparam int STAT_SNAP = 2;

    // Reset values
    localparam logic RST_SNAP_EN = 1'b0;
    localparam logic RST_SNAP_POL = 1'b0;
    localparam logic RST_OUT_POL = 1'b1;
    localparam logic [3:0] RST_SEL = 4'h0;

    // Output-select code groups: upper bits pick the mode, lower bits the outputs
    typedef enum logic [1:0] {
        DTP_STANDARD,
        DTP_WIDTH,
        DTP_DELAY,
        DTP_FREQ
    } dtp_mode_e;

    typedef struct packed {
        logic meta;
        logic stable;
    } dtp_sync_s;

    typedef struct packed {
        logic [31:0] tick_cnt;
        logic tick;
        logic snap_samp;
        logic snap_prev;
        logic snap_edge;
        logic snap_en;
        logic snap_pol;
        logic out_pol;
        logic sec_custom;
        logic [3:0] out_sel;
        logic [15:0] w_ticks;
        logic [15:0] d_ticks;
        logic [15:0] w2_ticks;
        logic [31:0] fine_width;
        logic [31:0] fine_delay;
        logic [31:0] fine_half;
        logic prim_act;
        logic [31:0] prim_rem;
        logic [31:0] prim_el;
        logic sec_act;
        logic sec_armed;
        logic sec_with_prim;
        logic [31:0] fine_cnt;
        logic out_p;
        logic out_s;
        logic [31:0] rd_data;
    } dtp_state_s;

endpackage : dtp_pkg

// File: src/dtp_sync.sv
// Two-stage synchroniser for a level from outside the clock domain
`timescale 1ns/1ns
module dtp_sync
    import dtp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic async_in,
    input wire logic rst_val,
    output logic sync_out
);

    dtp_sync_s st_q;
    dtp_sync_s st_d;

    always_comb begin
        st_d.meta = async_in;
        st_d.stable = st_q.meta;
    end

    // Reset loads zero; the rst_val tie-off that the caller passes is not used
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign sync_out = st_q.stable;

endmodule : dtp_sync

// File: src/dtp_trigger_out.sv
// Dual trigger pulse output: primary pulse, secondary modes and snapshot trigger
`timescale 1ns/1ns
// Overview of operation
// (R1) Active snapshot edge fires trigger when enabled
// (R2) Snapshot trigger enable resets off, reads back
// (R3) Snapshot pulses add to any trigger mode
// (R4) Only dedicated snapshot pin triggers pulses
// (R5) Sample snapshot every 40 us tick
// (R6) Both outputs share polarity and source
// (R7) Primary at least 40 us; zero gives spike
// (R8) Standard: copy, or delayed/width within primary
// (R9) Standard values rounded to 40 us steps
// (R10) Precise width starts with primary, fine width
// (R11) Codes 5,6,7 select width-mode outputs
// (R12) Precise delay in fine steps after primary
// (R13) Delayed pulse clears with primary or tick
// (R14) Codes 9,10,11 select delay-mode outputs
// (R15) Frequency mode: secondary free-runs, 50% duty
// (R16) No phase sync between frequency outputs
// (R17) Codes 13,14,15 select frequency-mode outputs
// (R18) Primary width from common width setting
// (R19) Snapshot polarity selects the active edge
// (R20) Compare current and previous tick samples
module dtp_trigger_out
    import dtp_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYC_DEF
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic trig_req,
    input wire logic snap_pin,
    output logic primary_output,
    output logic secondary_output
);

    localparam logic [31:0] TICK_C = 32'(TICK_CYC);
    localparam logic [31:0] EARLY_C = 32'(EARLY_CYC);
    localparam logic [31:0] SPIKE_C = 32'(SPIKE_CYC);

    dtp_state_s st_q;
    dtp_state_s st_d;
    logic snap_sync;
    logic fire;
    logic start;
    logic snap_fire;
    dtp_mode_e mode;
    logic sel_p;
    logic sel_s;
    logic [31:0] std_on_c;
    logic [31:0] std_off_c;
    logic [22:0] wr_us;
    logic [15:0] wr_ticks;

    dtp_sync u_snap_sync (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .async_in(snap_pin), // R4
        .rst_val(1'b0),
        .sync_out(snap_sync)
    );

    // Code 0..4 or an unused low pair falls back to the standard mode
    always_comb begin
        if (st_q.out_sel[1:0] == 2'h0) begin
            mode = DTP_STANDARD;
        end else begin
            mode = dtp_mode_e'(st_q.out_sel[3:2]);
        end
        sel_p = (mode == DTP_STANDARD) || st_q.out_sel[0]; // R11 R14 R17
        sel_s = (mode == DTP_STANDARD) || st_q.out_sel[1]; // R11 R14 R17
    end

    // Snapshot pulses join the ordinary trigger request, independent of mode
    assign snap_fire = st_q.snap_edge && st_q.snap_en; // R1 R3
    assign fire = trig_req || snap_fire; // R6
    assign start = fire && !st_q.prim_act;

    // Standard-mode secondary window within the primary pulse
    assign std_on_c = 32'(st_q.d_ticks) * TICK_C;
    assign std_off_c = 32'(32'(st_q.d_ticks) + 32'(st_q.w2_ticks)) * TICK_C;

    // Microseconds to 40 us steps, rounded to nearest and clipped
    always_comb begin
        wr_us = (reg_wdata[31:23] != 9'h000) ? MAX_US : reg_wdata[22:0];
        if (wr_us > MAX_US) begin
            wr_us = MAX_US;
        end
        wr_ticks = 16'((wr_us + ROUND_US) / STEP_US); // R9
    end

    always_comb begin
        st_d = st_q;
        st_d.tick = 1'b0;
        st_d.snap_edge = 1'b0;

        // Sampling tick
        if (st_q.tick_cnt >= TICK_C - 32'h00000001) begin
            st_d.tick_cnt = '0;
            st_d.tick = 1'b1;
        end else begin
            st_d.tick_cnt = st_q.tick_cnt + 32'h00000001;
        end

        // Snapshot level taken once per tick, normalised to active-high
        if (st_q.tick) begin
            st_d.snap_samp = snap_sync ~^ st_q.snap_pol; // R5 R19
            st_d.snap_prev = st_q.snap_samp;
            st_d.snap_edge = (snap_sync ~^ st_q.snap_pol) && !st_q.snap_samp; // R20
        end

        // Primary pulse
        if (start) begin
            st_d.prim_act = 1'b1;
            st_d.prim_el = '0;
            if (st_q.w_ticks == 16'h0000) begin
                st_d.prim_rem = SPIKE_C; // R7
            end else begin
                st_d.prim_rem = 32'(st_q.w_ticks) * TICK_C; // R7 R18
            end
        end else if (st_q.prim_act) begin
            st_d.prim_el = st_q.prim_el + 32'h00000001;
            st_d.prim_rem = st_q.prim_rem - 32'h00000001;
            if (st_q.prim_rem <= 32'h00000001) begin
                st_d.prim_act = 1'b0;
            end
        end

        // Secondary pulse
        unique case (mode)
            DTP_STANDARD: begin
                st_d.sec_armed = 1'b0;
                if (!st_q.sec_custom) begin
                    st_d.sec_act = st_d.prim_act; // R8
                end else begin
                    st_d.sec_act = st_d.prim_act && (st_d.prim_el >= std_on_c)
                        && ((st_q.w2_ticks == 16'h0000) || (st_d.prim_el < std_off_c)); // R8
                end
            end
            DTP_WIDTH: begin
                st_d.sec_armed = 1'b0;
                if (start) begin
                    st_d.sec_act = (st_q.fine_width != 32'h00000000); // R10
                    st_d.fine_cnt = st_q.fine_width;
                end else if (st_q.sec_act) begin
                    st_d.fine_cnt = st_q.fine_cnt - 32'h00000001;
                    if (st_q.fine_cnt <= 32'h00000001) begin
                        st_d.sec_act = 1'b0;
                    end
                end
            end
            DTP_DELAY: begin
                // Clearing first so that a fresh set in the same cycle stands
                if (st_q.sec_act) begin
                    if (st_q.sec_with_prim ? !st_d.prim_act : st_q.tick) begin
                        st_d.sec_act = 1'b0; // R13
                    end
                end
                if (start) begin
                    if (st_q.fine_delay == 32'h00000000) begin
                        st_d.sec_act = 1'b1; // R12
                        st_d.sec_armed = 1'b0;
                        st_d.sec_with_prim = (st_d.prim_rem >= EARLY_C); // R13
                    end else begin
                        st_d.sec_armed = 1'b1;
                        st_d.fine_cnt = st_q.fine_delay - 32'h00000001;
                    end
                end else if (st_q.sec_armed) begin
                    if (st_q.fine_cnt == 32'h00000000) begin
                        st_d.sec_armed = 1'b0;
                        st_d.sec_act = 1'b1; // R12
                        st_d.sec_with_prim = st_q.prim_act && (st_q.prim_rem >= EARLY_C); // R13
                    end else begin
                        st_d.fine_cnt = st_q.fine_cnt - 32'h00000001;
                    end
                end
            end
            DTP_FREQ: begin
                // Free-running; no phase lock to the primary trigger
                st_d.sec_armed = 1'b0;
                if (st_q.fine_cnt == 32'h00000000) begin
                    st_d.sec_act = !st_q.sec_act; // R15 R16
                    if (st_q.fine_half == 32'h00000000) begin
                        st_d.fine_cnt = '0;
                    end else begin
                        st_d.fine_cnt = st_q.fine_half - 32'h00000001;
                    end
                end else begin
                    st_d.fine_cnt = st_q.fine_cnt - 32'h00000001;
                end
            end
        endcase

        // Shared polarity; unselected output sits at the inactive level
        st_d.out_p = (sel_p && st_q.prim_act) ~^ st_q.out_pol; // R6 R11 R14 R17
        st_d.out_s = (sel_s && st_q.sec_act) ~^ st_q.out_pol; // R6 R11 R14 R17

        // Register writes
        if (reg_wr) begin
            unique case (reg_addr)
                REG_CTRL: begin
                    st_d.snap_en = reg_wdata[CTRL_SNAP_EN]; // R2
                    st_d.snap_pol = reg_wdata[CTRL_SNAP_POL]; // R19
                    st_d.out_pol = reg_wdata[CTRL_OUT_POL];
                    st_d.sec_custom = reg_wdata[CTRL_SEC_CUSTOM];
                    st_d.out_sel = reg_wdata[CTRL_SEL_LO +: 4];
                end
                REG_WIDTH: st_d.w_ticks = wr_ticks;
                REG_SDELAY: st_d.d_ticks = wr_ticks;
                REG_SWIDTH: st_d.w2_ticks = wr_ticks;
                REG_FWIDTH: st_d.fine_width = reg_wdata;
                REG_FDELAY: st_d.fine_delay = reg_wdata;
                REG_FHALF: st_d.fine_half = reg_wdata;
                default: begin
                end
            endcase
        end

        // Register reads; unmapped addresses answer zero
        st_d.rd_data = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                REG_CTRL: begin
                    st_d.rd_data[CTRL_SNAP_EN] = st_q.snap_en; // R2
                    st_d.rd_data[CTRL_SNAP_POL] = st_q.snap_pol;
                    st_d.rd_data[CTRL_OUT_POL] = st_q.out_pol;
                    st_d.rd_data[CTRL_SEC_CUSTOM] = st_q.sec_custom;
                    st_d.rd_data[CTRL_SEL_LO +: 4] = st_q.out_sel;
                end
                REG_WIDTH: st_d.rd_data = 32'(st_q.w_ticks) * 32'(STEP_US);
                REG_SDELAY: st_d.rd_data = 32'(st_q.d_ticks) * 32'(STEP_US);
                REG_SWIDTH: st_d.rd_data = 32'(st_q.w2_ticks) * 32'(STEP_US);
                REG_FWIDTH: st_d.rd_data = st_q.fine_width;
                REG_FDELAY: st_d.rd_data = st_q.fine_delay;
                REG_FHALF: st_d.rd_data = st_q.fine_half;
                REG_STATUS: begin
                    st_d.rd_data[STAT_PRIM] = st_q.prim_act;
                    st_d.rd_data[STAT_SEC] = st_q.sec_act;
                    st_d.rd_data[STAT_SNAP] = st_q.snap_samp;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= '0;
            st_q.snap_en <= RST_SNAP_EN; // R2
            st_q.snap_pol <= RST_SNAP_POL;
            st_q.out_pol <= RST_OUT_POL;
            st_q.out_sel <= RST_SEL;
            st_q.out_p <= ~RST_OUT_POL;
            st_q.out_s <= ~RST_OUT_POL;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata = st_q.rd_data;
    assign primary_output = st_q.out_p;
    assign secondary_output = st_q.out_s;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    a_snap_fires: // R1
    assert property (st_q.snap_edge && st_q.snap_en && !st_q.prim_act |=> st_q.prim_act)
    else $error("Enabled snapshot edge did not start the primary pulse");

    a_start_cause: // R4
    assert property ($rose(st_q.prim_act) |-> $past(trig_req) || $past(snap_fire))
    else $error("Primary pulse started without a trigger or snapshot event");

    a_en_readback: // R2
    assert property (reg_rd && reg_addr == REG_CTRL
        |=> reg_rdata[CTRL_SNAP_EN] == $past(st_q.snap_en))
    else $error("Snapshot trigger enable read back wrong");

    a_sample_tick: // R5
    assert property (!st_q.tick |=> $stable(st_q.snap_samp))
    else $error("Snapshot sample changed off the tick");

    a_shared_pol: // R6
    assert property (!st_q.prim_act && !st_q.sec_act
        |=> primary_output == !$past(st_q.out_pol) && secondary_output == !$past(st_q.out_pol))
    else $error("Idle outputs not at the shared inactive level");

    a_prim_min_width: // R7
    assert property ($rose(st_q.prim_act) && st_q.w_ticks != 16'h0000 |-> st_q.prim_act [*8])
    else $error("Primary pulse shorter than its width");

    a_zero_spike: // R7
    assert property ($rose(st_q.prim_act) && $past(st_q.w_ticks) == 16'h0000
        |-> ##[1:200] !st_q.prim_act)
    else $error("Zero width did not give a short spike");

    a_std_within: // R8
    assert property (mode == DTP_STANDARD && st_q.sec_act |-> st_q.prim_act)
    else $error("Standard secondary outside the primary pulse");

    a_width_start: // R10
    assert property (mode == DTP_WIDTH && $stable(mode) && $rose(st_q.prim_act)
        && $past(st_q.fine_width) != 32'h00000000 |-> st_q.sec_act)
    else $error("Precise width pulse did not start with primary");

    a_sel_inactive: // R11
    assert property (!sel_p |=> primary_output == !$past(st_q.out_pol))
    else $error("Unselected primary output not inactive");

    a_delay_clear: // R13
    assert property (mode == DTP_DELAY && st_q.sec_act && st_q.sec_with_prim
        && $fell(st_q.prim_act) |-> !st_q.sec_act)
    else $error("Delayed pulse did not clear with the primary");

    a_freq_toggle: // R15
    assert property (mode == DTP_FREQ && $stable(mode) && st_q.fine_cnt != 32'h00000000
        |=> $stable(st_q.sec_act))
    else $error("Frequency output toggled before half period");

endmodule : dtp_trigger_out
